//--- hdl/tmc_timer.sv
// Behaviour
// R1 - High-byte location accesses shared holding byte
// R2 - Low read loads holding; low write commits
// R3 - Counter clears, increments or decrements per tick
// R4 - Tick from prescaler or external pin
// R5 - Select zero stops; CPU access still works
// R6 - CPU write beats count or clear
// R7 - Four-bit mode split over controls A, B
// R8 - Overflow flag set per mode, interrupts
// R9 - Capture on configured edge, pin or comparator
// R10 - Capture copies count, sets flag together
// R11 - Enabled flag interrupts; ack or one clears
// R12 - Capture read low first, high via holding
// R13 - Capture writable only in capture-top modes
// R14 - Status bit picks comparator as source
// R15 - Sources synchronised; filter adds four cycles
// R16 - Capture input off in capture-top modes
// R17 - Own pin drive triggers capture normally
// R18 - Filter output changes after four equal samples
// R19 - Filter enable bit, runs on system clock
// R20 - One held byte serves several writes
// R21 - Single holding byte for all wide registers
// R22 - Bottom zero, max all ones, top per mode
// R23 - Software writes high first, reads low first
// R24 - Edge select bit, previous versus current
`timescale 1ns/10ps
module tmc_timer (
  input  wire logic clock,
  input  wire logic rst,
  tmc_bus_if.timer  bus,
  input  wire logic extClkPin,
  input  wire logic capPinI,
  output logic      capPinO,
  output logic      capPinOe,
  input  wire logic compOut
);
  import tmc_pkg::*;

  typedef struct packed {
    logic [7:0]  ctrlA;
    logic [7:0]  ctrlB;
    logic [7:0]  cmpStat;
    logic [7:0]  portCtl;
    logic [7:0]  mask;
    logic [15:0] cnt;
    logic [15:0] cap;
    logic [15:0] cmpA;
    logic [7:0]  temp;
    logic        ovf;
    logic        capF;
    logic        down;
    logic [9:0]  pre;
    logic [2:0]  extSync;
    logic        extLvl;
    logic        extPrev;
    logic [2:0]  pinSync;
    logic        pinLvl;
    logic [2:0]  cmpSync;
    logic        cmpLvl;
    logic [2:0]  filt;
    logic        filtOut;
    logic        edgePrev;
    logic [7:0]  rdata;
    logic        capIrq;
    logic        ovfIrq;
  } tmc_timer_t;

  tmc_timer_t  s_q;
  tmc_timer_t  s_d;
  logic [3:0]  mode;
  logic [15:0] top;
  logic        icrTop;
  logic        atTop;
  logic        atBottom;
  logic        atMax;
  logic        tick;
  logic        ovfSet;
  logic        src;
  logic        detIn;
  logic        trig;
  logic        wrFlags;

  always_comb begin
    s_d = s_q;
    // --------------------------------------------------------------------
    // Mode decode and sequence limits
    // --------------------------------------------------------------------
    mode     = {s_q.ctrlB[4:3], s_q.ctrlA[1:0]}; // R7
    top      = tmc_top_of(mode, s_q.cmpA, s_q.cap); // R22
    icrTop   = tmc_in(MODES_ICR_TOP, mode);
    atTop    = s_q.cnt == top; // R3
    atBottom = s_q.cnt == CNT_BOTTOM; // R22
    atMax    = s_q.cnt == CNT_MAX; // R22

    // --------------------------------------------------------------------
    // Pin synchronisers, level taken when stages two and three agree
    // --------------------------------------------------------------------
    s_d.extSync = {s_q.extSync[1:0], extClkPin};
    s_d.pinSync = {s_q.pinSync[1:0], capPinI};
    s_d.cmpSync = {s_q.cmpSync[1:0], compOut}; // R15
    if (s_q.extSync[2] == s_q.extSync[1]) s_d.extLvl = s_q.extSync[2];
    if (s_q.pinSync[2] == s_q.pinSync[1]) s_d.pinLvl = s_q.pinSync[2];
    if (s_q.cmpSync[2] == s_q.cmpSync[1]) s_d.cmpLvl = s_q.cmpSync[2];
    s_d.extPrev = s_q.extLvl;

    // --------------------------------------------------------------------
    // Timer tick selection
    // --------------------------------------------------------------------
    s_d.pre = s_q.pre + PRE_ONE;
    unique case (s_q.ctrlB[2:0])
      CS_STOP:     tick = 1'b0; // R5
      CS_DIV1:     tick = 1'b1; // R4
      CS_DIV8:     tick = (s_q.pre & TAP_DIV8) == TAP_DIV8;
      CS_DIV64:    tick = (s_q.pre & TAP_DIV64) == TAP_DIV64;
      CS_DIV256:   tick = (s_q.pre & TAP_DIV256) == TAP_DIV256;
      CS_DIV1024:  tick = s_q.pre == TAP_DIV1024;
      CS_EXT_FALL: tick = !s_q.extLvl && s_q.extPrev; // R4
      CS_EXT_RISE: tick = s_q.extLvl && !s_q.extPrev;
    endcase

    // --------------------------------------------------------------------
    // Counter unit
    // --------------------------------------------------------------------
    ovfSet = 1'b0;
    if (tick) begin
      if (tmc_in(MODES_DUAL, mode)) begin
        // Up to top, back down to bottom
        if (!s_q.down && (atTop || atMax)) begin
          s_d.down = 1'b1;
          s_d.cnt  = s_q.cnt - CNT_ONE; // R3
        end else if (s_q.down && atBottom) begin
          s_d.down = 1'b0;
          s_d.cnt  = s_q.cnt + CNT_ONE;
          ovfSet   = 1'b1; // R8
        end else if (s_q.down) begin
          s_d.cnt = s_q.cnt - CNT_ONE;
        end else begin
          s_d.cnt = s_q.cnt + CNT_ONE;
        end
      end else begin
        s_d.down = 1'b0;
        s_d.cnt  = atTop ? CNT_BOTTOM : s_q.cnt + CNT_ONE; // R3
        ovfSet   = tmc_in(MODES_FAST, mode) ? atTop : atMax; // R8
      end
    end

    // --------------------------------------------------------------------
    // Capture path: source, filter, edge detector
    // --------------------------------------------------------------------
    src = s_q.cmpStat[CMPSTAT_SEL] ? s_q.cmpLvl : s_q.pinLvl; // R14 R17
    // Three held samples plus the current one, so four cycles of delay
    s_d.filt = {s_q.filt[1:0], src}; // R19
    if (&{s_q.filt, src}) s_d.filtOut = 1'b1; // R18 R15
    else if (~|{s_q.filt, src}) s_d.filtOut = 1'b0; // R18
    detIn = s_q.ctrlB[CTLB_FILT_EN] ? s_q.filtOut : src; // R15 R19
    s_d.edgePrev = detIn;
    trig = s_q.ctrlB[CTLB_EDGE_RISE] ? (detIn && !s_q.edgePrev)
                                      : (!detIn && s_q.edgePrev); // R24 R9
    trig = trig && !icrTop; // R16
    if (trig) s_d.cap = s_q.cnt; // R10

    // --------------------------------------------------------------------
    // CPU writes, applied last so they win over counting
    // --------------------------------------------------------------------
    wrFlags = 1'b0;
    if (bus.wr) begin
      unique case (bus.addr)
        ADDR_CTRL_A:   s_d.ctrlA = bus.wdata;
        ADDR_CTRL_B:   s_d.ctrlB = bus.wdata;
        ADDR_CNT_LO: begin
          s_d.cnt = {s_q.temp, bus.wdata}; // R2 R6 R20
        end
        ADDR_CNT_HI,
        ADDR_CAP_HI,
        ADDR_CMPA_HI:  s_d.temp = bus.wdata; // R1 R21
        ADDR_CAP_LO: begin
          if (icrTop) s_d.cap = {s_q.temp, bus.wdata}; // R13 R20
        end
        ADDR_CMPA_LO:  s_d.cmpA = {s_q.temp, bus.wdata}; // R20 R21
        ADDR_FLAGS:    wrFlags = 1'b1;
        ADDR_MASK:     s_d.mask = bus.wdata;
        ADDR_CMP_STAT: s_d.cmpStat = bus.wdata; // R14
        ADDR_PORT_CTL: s_d.portCtl = bus.wdata; // R17
        default:       ;
      endcase
    end

    // --------------------------------------------------------------------
    // CPU reads, data stands in the following cycle
    // --------------------------------------------------------------------
    s_d.rdata = RST_BYTE;
    if (bus.rd) begin
      unique case (bus.addr)
        ADDR_CTRL_A:   s_d.rdata = s_q.ctrlA;
        ADDR_CTRL_B:   s_d.rdata = s_q.ctrlB;
        ADDR_CNT_LO: begin
          s_d.rdata = s_q.cnt[7:0]; // R2 R5
          s_d.temp  = s_q.cnt[15:8]; // R2
        end
        ADDR_CAP_LO: begin
          s_d.rdata = s_q.cap[7:0];
          s_d.temp  = s_q.cap[15:8]; // R12
        end
        ADDR_CNT_HI,
        ADDR_CAP_HI:   s_d.rdata = s_q.temp; // R1 R12
        ADDR_CMPA_LO:  s_d.rdata = s_q.cmpA[7:0];
        ADDR_CMPA_HI:  s_d.rdata = s_q.cmpA[15:8];
        ADDR_FLAGS:    s_d.rdata = {6'h00, s_q.capF, s_q.ovf};
        ADDR_MASK:     s_d.rdata = s_q.mask;
        ADDR_CMP_STAT: s_d.rdata = s_q.cmpStat;
        ADDR_PORT_CTL: s_d.rdata = s_q.portCtl;
        default:       s_d.rdata = RST_BYTE;
      endcase
    end

    // --------------------------------------------------------------------
    // Flags: set wins over clear
    // --------------------------------------------------------------------
    s_d.ovf = (s_q.ovf && !(bus.ovfAck
               || (wrFlags && bus.wdata[FLAG_OVF]))) || ovfSet; // R8
    s_d.capF = (s_q.capF && !(bus.capAck
                || (wrFlags && bus.wdata[FLAG_CAP]))) || trig; // R10 R11
    s_d.ovfIrq = s_d.ovf && s_d.mask[FLAG_OVF]; // R8
    s_d.capIrq = s_d.capF && s_d.mask[FLAG_CAP]; // R11
  end

  // State register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign bus.rdata  = s_q.rdata;
  assign bus.capIrq = s_q.capIrq;
  assign bus.ovfIrq = s_q.ovfIrq;
  assign capPinO    = s_q.portCtl[PORT_OUT];
  assign capPinOe   = s_q.portCtl[PORT_OE];

endmodule

//--- shared/tmc_pkg.sv
package tmc_pkg;

  // ----------------------------------------------------------------------
  // Timer register map (byte locations on the 8-bit bus)
  // ----------------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL_A    = 4'h0;
  localparam logic [3:0] ADDR_CTRL_B    = 4'h1;
  localparam logic [3:0] ADDR_CNT_LO    = 4'h2;
  localparam logic [3:0] ADDR_CNT_HI    = 4'h3;
  localparam logic [3:0] ADDR_CAP_LO    = 4'h4;
  localparam logic [3:0] ADDR_CAP_HI    = 4'h5;
  localparam logic [3:0] ADDR_CMPA_LO   = 4'h6;
  localparam logic [3:0] ADDR_CMPA_HI   = 4'h7;
  localparam logic [3:0] ADDR_FLAGS     = 4'h8;
  localparam logic [3:0] ADDR_MASK      = 4'h9;
  localparam logic [3:0] ADDR_CMP_STAT  = 4'hA;
  localparam logic [3:0] ADDR_PORT_CTL  = 4'hB;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CTLB_FILT_EN   = 7;
  localparam int CTLB_EDGE_RISE = 6;
  localparam int FLAG_OVF       = 0;
  localparam int FLAG_CAP       = 1;
  localparam int CMPSTAT_SEL    = 0;
  localparam int PORT_OUT       = 0;
  localparam int PORT_OE        = 1;

  // ----------------------------------------------------------------------
  // Values after reset and count limits
  // ----------------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_MAX    = 16'hFFFF;
  localparam logic [15:0] CNT_ONE    = 16'h0001;
  localparam logic [15:0] TOP_8BIT   = 16'h00FF;
  localparam logic [15:0] TOP_9BIT   = 16'h01FF;
  localparam logic [15:0] TOP_10BIT  = 16'h03FF;
  localparam logic [9:0]  PRE_ONE    = 10'h001;

  // ----------------------------------------------------------------------
  // Mode classes, one bit per waveform mode code
  // ----------------------------------------------------------------------
  localparam logic [15:0] MODES_ICR_TOP = 16'h5500;
  localparam logic [15:0] MODES_OCR_TOP = 16'h8A10;
  localparam logic [15:0] MODES_DUAL    = 16'h0F0E;
  localparam logic [15:0] MODES_FAST    = 16'hC0E0;

  // ----------------------------------------------------------------------
  // Clock select codes and prescaler taps
  // ----------------------------------------------------------------------
  localparam logic [2:0] CS_STOP     = 3'h0;
  localparam logic [2:0] CS_DIV1     = 3'h1;
  localparam logic [2:0] CS_DIV8     = 3'h2;
  localparam logic [2:0] CS_DIV64    = 3'h3;
  localparam logic [2:0] CS_DIV256   = 3'h4;
  localparam logic [2:0] CS_DIV1024  = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam logic [9:0] TAP_DIV8    = 10'h007;
  localparam logic [9:0] TAP_DIV64   = 10'h03F;
  localparam logic [9:0] TAP_DIV256  = 10'h0FF;
  localparam logic [9:0] TAP_DIV1024 = 10'h3FF;

  // ----------------------------------------------------------------------
  // Controller register map and fields
  // ----------------------------------------------------------------------
  localparam logic [2:0] HADDR_TARGET  = 3'h0;
  localparam logic [2:0] HADDR_DATA_LO = 3'h1;
  localparam logic [2:0] HADDR_DATA_HI = 3'h2;
  localparam logic [2:0] HADDR_CMD     = 3'h3;
  localparam logic [2:0] HADDR_STATUS  = 3'h4;
  localparam int CMD_WR16    = 0;
  localparam int CMD_RD16    = 1;
  localparam int CMD_WR8     = 2;
  localparam int CMD_RD8     = 3;
  localparam int CMD_ACK_CAP = 4;
  localparam int CMD_ACK_OVF = 5;
  localparam logic [3:0] HI_BYTE_STEP = 4'h1;

  typedef enum logic [6:0] {
    H_IDLE   = 7'h01,
    H_WR_LO  = 7'h02,
    H_RD_HI  = 7'h04,
    H_GET_LO = 7'h08,
    H_GET_HI = 7'h10,
    H_WAIT8  = 7'h20,
    H_GET8   = 7'h40
  } tmc_host_state_t;

  // Membership of a mode code in a class mask
  function automatic logic tmc_in(input logic [15:0] cls,
                                  input logic [3:0]  mode);
    return cls[mode];
  endfunction

  // Highest value of the count sequence for a mode
  function automatic logic [15:0] tmc_top_of(input logic [3:0]  mode,
                                             input logic [15:0] cmpA,
                                             input logic [15:0] cap);
    if (tmc_in(MODES_ICR_TOP, mode)) return cap;
    if (tmc_in(MODES_OCR_TOP, mode)) return cmpA;
    if (!mode[3]) begin
      unique case (mode[1:0])
        2'h1:    return TOP_8BIT;
        2'h2:    return TOP_9BIT;
        2'h3:    return TOP_10BIT;
        default: return CNT_MAX;
      endcase
    end
    return CNT_MAX;
  endfunction

endpackage

//--- shared/tmc_bus_if.sv
`timescale 1ns/10ps
interface tmc_bus_if;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       capIrq;
  logic       ovfIrq;
  logic       capAck;
  logic       ovfAck;

  modport cpu (
    output addr, wdata, wr, rd, capAck, ovfAck,
    input  rdata, capIrq, ovfIrq
  );

  modport timer (
    input  addr, wdata, wr, rd, capAck, ovfAck,
    output rdata, capIrq, ovfIrq
  );
endinterface

//--- hdl/tmc_cpu.sv
`timescale 1ns/10ps
module tmc_cpu (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [2:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdata,
  tmc_bus_if.cpu          bus
);
  import tmc_pkg::*;

  typedef struct packed {
    tmc_host_state_t st;
    logic [3:0]      target;
    logic [7:0]      dataLo;
    logic [7:0]      dataHi;
    logic [7:0]      rdata;
    logic [3:0]      addr;
    logic [7:0]      wdata;
    logic            wr;
    logic            rd;
    logic            capAck;
    logic            ovfAck;
  } tmc_host_t;

  tmc_host_t s_q;
  tmc_host_t s_d;
  logic      cmdWr;

  // ----------------------------------------------------------------------
  // Sequencer of byte accesses
  // ----------------------------------------------------------------------
  always_comb begin
    s_d        = s_q;
    s_d.wr     = 1'b0;
    s_d.rd     = 1'b0;
    s_d.capAck = 1'b0;
    s_d.ovfAck = 1'b0;
    s_d.rdata  = RST_BYTE;
    cmdWr      = regWr && (regAddr == HADDR_CMD);
    unique case (s_q.st)
      H_IDLE: begin
        if (cmdWr && regWdata[CMD_WR16]) begin
          // High byte first into the shared holding byte
          s_d.addr  = s_q.target + HI_BYTE_STEP; // R23 R13
          s_d.wdata = s_q.dataHi;
          s_d.wr    = 1'b1;
          s_d.st    = H_WR_LO;
        end else if (cmdWr && regWdata[CMD_RD16]) begin
          // Low byte first, it loads the holding byte
          s_d.addr = s_q.target; // R23 R12
          s_d.rd   = 1'b1;
          s_d.st   = H_RD_HI;
        end else if (cmdWr && regWdata[CMD_WR8]) begin
          // Single byte, lets software reuse one held high byte
          s_d.addr  = s_q.target; // R20 R14
          s_d.wdata = s_q.dataLo;
          s_d.wr    = 1'b1;
        end else if (cmdWr && regWdata[CMD_RD8]) begin
          s_d.addr = s_q.target;
          s_d.rd   = 1'b1;
          s_d.st   = H_WAIT8;
        end
      end
      H_WR_LO: begin
        s_d.addr  = s_q.target; // R23
        s_d.wdata = s_q.dataLo;
        s_d.wr    = 1'b1;
        s_d.st    = H_IDLE;
      end
      H_RD_HI: begin
        s_d.addr = s_q.target + HI_BYTE_STEP; // R12
        s_d.rd   = 1'b1;
        s_d.st   = H_GET_LO;
      end
      H_GET_LO: begin
        s_d.dataLo = bus.rdata;
        s_d.st     = H_GET_HI;
      end
      H_GET_HI: begin
        s_d.dataHi = bus.rdata;
        s_d.st     = H_IDLE;
      end
      H_WAIT8: s_d.st = H_GET8;
      H_GET8: begin
        s_d.dataLo = bus.rdata;
        s_d.st     = H_IDLE;
      end
    endcase
    // Interrupt service acknowledges, any state
    if (cmdWr) begin
      s_d.capAck = regWdata[CMD_ACK_CAP];
      s_d.ovfAck = regWdata[CMD_ACK_OVF];
    end
    // Own registers, loaded only while idle
    if (regWr && s_q.st == H_IDLE) begin
      unique case (regAddr)
        HADDR_TARGET:  s_d.target = regWdata[3:0];
        HADDR_DATA_LO: s_d.dataLo = regWdata;
        HADDR_DATA_HI: s_d.dataHi = regWdata;
        default:       ;
      endcase
    end
    if (regRd) begin
      unique case (regAddr)
        HADDR_TARGET:  s_d.rdata = {4'h0, s_q.target};
        HADDR_DATA_LO: s_d.rdata = s_q.dataLo;
        HADDR_DATA_HI: s_d.rdata = s_q.dataHi;
        HADDR_STATUS:  s_d.rdata = {5'h00, bus.ovfIrq, bus.capIrq,
                                    s_q.st != H_IDLE};
        default:       s_d.rdata = RST_BYTE;
      endcase
    end
  end

  // State register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= '{st: H_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign regRdata   = s_q.rdata;
  assign bus.addr   = s_q.addr;
  assign bus.wdata  = s_q.wdata;
  assign bus.wr     = s_q.wr;
  assign bus.rd     = s_q.rd;
  assign bus.capAck = s_q.capAck;
  assign bus.ovfAck = s_q.ovfAck;

endmodule

//--- dv/tmc_properties.sv
`timescale 1ns/10ps
module tmc_properties
  import tmc_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       capIrq,
  input wire logic       ovfIrq,
  input wire logic       capAck,
  input wire logic       ovfAck
);
  // ----------------------------------------------------------------
  // Bus checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  one_strobe_a: assert property (
    !(wr && rd)) else $error("write and read strobes together");
  rdata_idle_a: assert property (
    !$past(rd) |-> rdata == RST_BYTE) else $error("rdata not idle");
  write_order_a: assert property (
    wr && $past(wr) |-> addr == $past(addr) - 4'h1 ##1 !wr)
    else $error("wide write not high then low");
  read_order_a: assert property (
    rd && $past(rd) |-> addr == $past(addr) + 4'h1 ##1 !rd)
    else $error("wide read not low then high");
  cap_ack_a: assert property (
    capAck |=> !capAck && !capIrq) else $error("capture ack left flag");
  ovf_ack_a: assert property (
    ovfAck |=> !ovfAck && !ovfIrq) else $error("overflow ack left flag");
  cap_fall_a: assert property (
    $fell(capIrq) |-> $past(capAck) || $past(wr))
    else $error("capture irq dropped without cause");
  ovf_fall_a: assert property (
    $fell(ovfIrq) |-> $past(ovfAck) || $past(wr))
    else $error("overflow irq dropped without cause");
endmodule

//--- dv/test_timer16_counter_capture.sv
`timescale 1ns/10ps
module test_timer16_counter_capture;
  import tmc_pkg::*;
  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWdata = 8'h00;
  logic       regWr = 1'b0;
  logic       regRd = 1'b0;
  logic [7:0] regRdata;
  logic       extClkPin = 1'b0;
  logic       capDrv = 1'b0;
  logic       compOut = 1'b0;
  logic       capPinO;
  logic       capPinOe;
  wire logic  capPinI;
  int         n_mismatch = 0;
  int         compares = 0;
  logic [15:0] v;

  // Clock and pin level
  always #5 clock = ~clock;
  assign capPinI = capPinOe ? capPinO : capDrv;

  tmc_bus_if tmc_bus_if_i ();
  tmc_cpu tmc_cpu_i (.clock(clock), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .bus(tmc_bus_if_i));
  tmc_timer tmc_timer_i (.clock(clock), .rst(rst), .bus(tmc_bus_if_i),
    .extClkPin(extClkPin), .capPinI(capPinI), .capPinO(capPinO),
    .capPinOe(capPinOe), .compOut(compOut));
  tmc_properties tmc_properties_i (.clock(clock), .rst(rst),
    .addr(tmc_bus_if_i.addr), .wdata(tmc_bus_if_i.wdata),
    .wr(tmc_bus_if_i.wr), .rd(tmc_bus_if_i.rd),
    .rdata(tmc_bus_if_i.rdata), .capIrq(tmc_bus_if_i.capIrq),
    .ovfIrq(tmc_bus_if_i.ovfIrq), .capAck(tmc_bus_if_i.capAck),
    .ovfAck(tmc_bus_if_i.ovfAck));

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
  endtask

  task automatic rreg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask

  task automatic cmd(input int c);
    logic [7:0] s;
    wreg(HADDR_CMD, 8'h01 << c);
    for (int i = 0; i < 20; i++) begin
      rreg(HADDR_STATUS, s);
      if (s[0] === 1'b0) return;
    end
    n_mismatch++;
    $display("FAIL %0t controller stays busy", $time);
    wrap_up();
  endtask

  task automatic tw8(input logic [3:0] a, input logic [7:0] d);
    wreg(HADDR_TARGET, {4'h0, a});
    wreg(HADDR_DATA_LO, d);
    cmd(CMD_WR8);
  endtask

  task automatic c8(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] b;
    wreg(HADDR_TARGET, {4'h0, a});
    cmd(CMD_RD8);
    rreg(HADDR_DATA_LO, b);
    chk({8'h00, b}, {8'h00, e});
  endtask

  task automatic w16(input logic [3:0] a, input logic [15:0] d);
    wreg(HADDR_TARGET, {4'h0, a});
    wreg(HADDR_DATA_LO, d[7:0]);
    wreg(HADDR_DATA_HI, d[15:8]);
    cmd(CMD_WR16);
  endtask

  task automatic r16(input logic [3:0] a, output logic [15:0] d);
    logic [7:0] lo;
    logic [7:0] hi;
    wreg(HADDR_TARGET, {4'h0, a});
    cmd(CMD_RD16);
    rreg(HADDR_DATA_LO, lo);
    rreg(HADDR_DATA_HI, hi);
    d = {hi, lo};
  endtask

  task automatic c16(input logic [3:0] a, input logic [15:0] e);
    logic [15:0] g;
    r16(a, g);
    chk(g, e);
  endtask

  task automatic cst(input logic [7:0] e);
    logic [7:0] s;
    rreg(HADDR_STATUS, s);
    chk({8'h00, s}, {8'h00, e});
  endtask

  // External tick pulses, then time for the synchroniser to settle
  task automatic pulse(input int n);
    for (int i = 0; i < n; i++) begin
      extClkPin <= 1'b1;
      repeat (4) @(posedge clock);
      extClkPin <= 1'b0;
      repeat (4) @(posedge clock);
    end
    repeat (8) @(posedge clock);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    c8(ADDR_CTRL_B, 8'h00);
    c8(4'hC, 8'h00);
    w16(ADDR_CNT_LO, 16'h01FF);
    repeat (30) @(posedge clock);
    c16(ADDR_CNT_LO, 16'h01FF);
    $display("test access done");
    w16(ADDR_CNT_LO, 16'hA511);
    tw8(ADDR_CMPA_LO, 8'h22);
    c16(ADDR_CMPA_LO, 16'hA522);
    c16(ADDR_CNT_LO, 16'hA511);
    c8(ADDR_CAP_HI, 8'hA5);
    $display("test holding done");
    w16(ADDR_CNT_LO, 16'hFFF0);
    tw8(ADDR_CTRL_B, {5'h00, CS_DIV1});
    repeat (20) @(posedge clock);
    w16(ADDR_CNT_LO, 16'h8000);
    r16(ADDR_CNT_LO, v);
    chk({15'h0000, v >= 16'h8000 && v < 16'h8040}, 16'h0001);
    tw8(ADDR_CTRL_B, 8'h00);
    c8(ADDR_FLAGS, 8'h01);
    tw8(ADDR_MASK, 8'h01);
    cst(8'h04);
    cmd(CMD_ACK_OVF);
    cst(8'h00);
    r16(ADDR_CNT_LO, v);
    repeat (30) @(posedge clock);
    c16(ADDR_CNT_LO, v);
    w16(ADDR_CNT_LO, 16'h0000);
    tw8(ADDR_CTRL_B, {5'h00, CS_EXT_RISE});
    pulse(5);
    tw8(ADDR_CTRL_B, 8'h00);
    c16(ADDR_CNT_LO, 16'h0005);
    $display("test counting done");
    w16(ADDR_CNT_LO, 16'h3C5A);
    tw8(ADDR_CTRL_B, 8'h40);
    tw8(ADDR_FLAGS, 8'h03);
    capDrv <= 1'b1;
    repeat (10) @(posedge clock);
    c16(ADDR_CAP_LO, 16'h3C5A);
    c8(ADDR_FLAGS, 8'h02);
    tw8(ADDR_MASK, 8'h02);
    cst(8'h02);
    cmd(CMD_ACK_CAP);
    cst(8'h00);
    tw8(ADDR_CTRL_B, 8'h00);
    w16(ADDR_CNT_LO, 16'h0102);
    capDrv <= 1'b0;
    repeat (10) @(posedge clock);
    c16(ADDR_CAP_LO, 16'h0102);
    w16(ADDR_CAP_LO, 16'h1111);
    c16(ADDR_CAP_LO, 16'h0102);
    tw8(ADDR_FLAGS, 8'h03);
    tw8(ADDR_CTRL_B, 8'hC0);
    w16(ADDR_CNT_LO, 16'h0077);
    capDrv <= 1'b1;
    repeat (2) @(posedge clock);
    capDrv <= 1'b0;
    repeat (12) @(posedge clock);
    c8(ADDR_FLAGS, 8'h00);
    capDrv <= 1'b1;
    repeat (14) @(posedge clock);
    c16(ADDR_CAP_LO, 16'h0077);
    capDrv <= 1'b0;
    tw8(ADDR_CTRL_B, 8'h40);
    tw8(ADDR_CMP_STAT, 8'h01);
    tw8(ADDR_FLAGS, 8'h03);
    w16(ADDR_CNT_LO, 16'h0ABC);
    compOut <= 1'b1;
    repeat (10) @(posedge clock);
    c16(ADDR_CAP_LO, 16'h0ABC);
    tw8(ADDR_CMP_STAT, 8'h00);
    tw8(ADDR_PORT_CTL, 8'h02);
    w16(ADDR_CNT_LO, 16'h0DEF);
    tw8(ADDR_PORT_CTL, 8'h03);
    repeat (10) @(posedge clock);
    c16(ADDR_CAP_LO, 16'h0DEF);
    $display("test capture done");
    tw8(ADDR_PORT_CTL, 8'h02);
    tw8(ADDR_CTRL_B, 8'h58);
    w16(ADDR_CAP_LO, 16'hBEEF);
    tw8(ADDR_FLAGS, 8'h03);
    tw8(ADDR_PORT_CTL, 8'h03);
    repeat (10) @(posedge clock);
    c16(ADDR_CAP_LO, 16'hBEEF);
    c8(ADDR_FLAGS, 8'h00);
    $display("test capture top done");
    tw8(ADDR_CTRL_B, {5'h00, CS_EXT_RISE});
    tw8(ADDR_CTRL_A, 8'h01);
    w16(ADDR_CNT_LO, 16'h00FE);
    tw8(ADDR_FLAGS, 8'h03);
    pulse(3);
    c16(ADDR_CNT_LO, 16'h00FD);
    w16(ADDR_CNT_LO, 16'h0001);
    pulse(2);
    c16(ADDR_CNT_LO, 16'h0001);
    c8(ADDR_FLAGS, 8'h01);
    tw8(ADDR_CTRL_B, {5'h00, CS_EXT_FALL});
    pulse(2);
    c16(ADDR_CNT_LO, 16'h0003);
    $display("test dual slope done");
    wrap_up();
  end
endmodule
